// file: hw/ext_irq_defines.svh
// Offsets, field positions, reset values and codes of the external pin interrupt unit.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef EXT_IRQ_DEFINES_SVH
`define EXT_IRQ_DEFINES_SVH

// Data-space offsets
`define EXT_IRQ_FLAGS_OFFSET         8'h3C
`define EXT_IRQ_ENABLES_OFFSET       8'h3D
`define EXT_IRQ_SENSE_CONTROL_OFFSET 8'h69

// Short I/O space lies this far below the data space
`define IO_SPACE_OFFSET              8'h20
`define IO_SPACE_TOP_BITS            2'h0

// Reset values
`define EXT_IRQ_FLAGS_RESET          3'h0
`define EXT_IRQ_ENABLES_RESET        3'h0
`define EXT_IRQ_SENSE_CONTROL_RESET  6'h00

// Sense control field positions, low bit of each two-bit field
`define SENSE_SELECT_0_LSB           0
`define SENSE_SELECT_1_LSB           2
`define SENSE_SELECT_2_LSB           4
`define SENSE_SELECT_WIDTH           2

// Sense select codes
`define SENSE_LOW_LEVEL              2'h0
`define SENSE_ANY_CHANGE             2'h1
`define SENSE_FALLING_EDGE           2'h2
`define SENSE_RISING_EDGE            2'h3

// Counts
`define EXT_IRQ_PIN_COUNT            3
`define PIN_CHANGE_INPUT_COUNT       39
`define PIN_CHANGE_GROUP_COUNT       5
`define PIN_CHANGE_GROUP_SIZE        8

`endif

// file: hw/ext_irq_pkg.sv
// Types shared by the external pin interrupt unit and its per-pin sense stage.
// Assumes the defines header is on the include path.
`include "ext_irq_defines.svh"

package ext_irq_pkg;

    typedef enum logic [1:0] {
        SENSE_LOW_LEVEL    = `SENSE_LOW_LEVEL,
        SENSE_ANY_CHANGE   = `SENSE_ANY_CHANGE,
        SENSE_FALLING_EDGE = `SENSE_FALLING_EDGE,
        SENSE_RISING_EDGE  = `SENSE_RISING_EDGE
    } sense_mode_type;

endpackage : ext_irq_pkg

// file: hw/pin_sense_stage.sv
// One pin: two-flop synchroniser, last-sample register and edge/change trigger.
// Assumes an asynchronous pin and a same-domain sample enable.
`timescale 1ns/1ns
`default_nettype none

module pin_sense_stage
    import ext_irq_pkg::*;
(
    // Clock and reset
    input  wire logic           core_clk,
    input  wire logic           rstn,
    // Pin and control
    input  wire logic           pinRaw,
    input  wire logic           sampleEn,
    input  wire sense_mode_type senseMode,
    // Results
    output logic                pinLevel,
    output logic                trigger
);

    logic syncFirst_q;
    logic syncSecond_q;
    logic lastSample_q;
    logic rise;
    logic fall;

    // Pin is sampled first, edges seen on the sampled value
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            syncFirst_q  <= 1'b1;
            syncSecond_q <= 1'b1;
        end else begin
            syncFirst_q  <= pinRaw;
            syncSecond_q <= syncFirst_q;
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            lastSample_q <= 1'b1;
        end else begin
            lastSample_q <= syncSecond_q;
        end
    end

    assign pinLevel = syncSecond_q;
    assign rise     = syncSecond_q & ~lastSample_q;
    assign fall     = ~syncSecond_q & lastSample_q;

    // Edges lost while the sample enable is low
    always_comb begin
        trigger = 1'b0;
        if (sampleEn) begin
            unique case (senseMode)
                SENSE_LOW_LEVEL:    trigger = 1'b0;
                SENSE_ANY_CHANGE:   trigger = rise | fall;
                SENSE_FALLING_EDGE: trigger = fall;
                SENSE_RISING_EDGE:  trigger = rise;
            endcase
        end
    end

endmodule : pin_sense_stage

`default_nettype wire

// file: hw/external_pin_interrupt_unit.sv
// External pin interrupt unit: three dedicated pins and five pin-change groups.
// Assumes the core's data-space port on core_clk and pads sampled regardless of direction.
`timescale 1ns/1ns
`default_nettype none

module external_pin_interrupt_unit
    import ext_irq_pkg::*;
#(
    parameter int PIN_COUNT  = `EXT_IRQ_PIN_COUNT,
    parameter int PC_COUNT   = `PIN_CHANGE_INPUT_COUNT,
    parameter int PC_GROUPS  = `PIN_CHANGE_GROUP_COUNT
)
(
    // Clock and reset
    input  wire logic                 core_clk,
    input  wire logic                 rstn,
    // Pads
    input  wire logic [PIN_COUNT-1:0] extIrqPin,
    input  wire logic [PC_COUNT-1:0]  pinChangeInput,
    // Core data-space port
    input  wire logic [7:0]           ioAddr,
    input  wire logic                 ioShortSpace,
    input  wire logic                 ioWrEn,
    input  wire logic [7:0]           ioWrData,
    input  wire logic                 ioRdEn,
    output logic      [7:0]           ioRdData,
    // Core state
    input  wire logic                 globalIrqEnable,
    input  wire logic                 ioClkRunning,
    // Pin-change control levels
    input  wire logic [PC_GROUPS-1:0] pinChangeGroupEnable,
    input  wire logic [PC_COUNT-1:0]  pinChangeMask,
    // Requests toward the core
    output logic      [PIN_COUNT-1:0] extIrqRequest,
    input  wire logic [PIN_COUNT-1:0] extIrqAck,
    output logic      [PC_GROUPS-1:0] pinChangeRequest,
    input  wire logic [PC_GROUPS-1:0] pinChangeAck,
    output logic      [PC_GROUPS-1:0] pinChangeFlags,
    // Asynchronous wake toward the sleep controller
    output logic                      wakeRequest
);

    logic [PIN_COUNT-1:0]   flags_q;
    logic [PIN_COUNT-1:0]   flags_d;
    logic [PIN_COUNT-1:0]   enables_q;
    logic [5:0]             sense_q;
    logic [PC_GROUPS-1:0]   pcFlags_q;
    logic [PC_GROUPS-1:0]   pcFlags_d;
    logic [7:0]             rdData_q;

    logic [PIN_COUNT-1:0]   pinLevel;
    logic [PIN_COUNT-1:0]   pinTrigger;
    logic [PIN_COUNT-1:0]   levelMode;
    logic [PC_COUNT-1:0]    pcLevel;
    logic [PC_COUNT-1:0]    pcToggle;
    logic [PC_COUNT-1:0]    pcHit;
    logic [PC_GROUPS-1:0]   pcGroupHit;
    logic [PC_GROUPS-1:0]   pcGroupAsync;
    logic [7:0]             dataAddr;
    logic                   addrValid;
    logic                   selFlags;
    logic                   selEnables;
    logic                   selSense;
    logic [PIN_COUNT-1:0]   flagClear;
    sense_mode_type         senseMode [PIN_COUNT];

    // Address decode: short form maps I/O 0x00..0x3F onto data 0x20..0x5F
    assign dataAddr  = ioShortSpace ? 8'(ioAddr + `IO_SPACE_OFFSET) : ioAddr;
    assign addrValid = !ioShortSpace || (ioAddr[7:6] == `IO_SPACE_TOP_BITS);
    assign selFlags   = addrValid && (dataAddr == `EXT_IRQ_FLAGS_OFFSET);
    assign selEnables = addrValid && (dataAddr == `EXT_IRQ_ENABLES_OFFSET);
    assign selSense   = addrValid && (dataAddr == `EXT_IRQ_SENSE_CONTROL_OFFSET);

    // Sense fields per pin
    assign senseMode[0] = sense_mode_type'(
        sense_q[`SENSE_SELECT_0_LSB +: `SENSE_SELECT_WIDTH]);
    assign senseMode[1] = sense_mode_type'(
        sense_q[`SENSE_SELECT_1_LSB +: `SENSE_SELECT_WIDTH]);
    assign senseMode[2] = sense_mode_type'(
        sense_q[`SENSE_SELECT_2_LSB +: `SENSE_SELECT_WIDTH]);

    // Dedicated pins: pad values taken whatever the pin direction
    genvar p;
    generate
        for (p = 0; p < PIN_COUNT; p++) begin : g_pin
            pin_sense_stage u_sense (
                .core_clk  (core_clk),
                .rstn      (rstn),
                .pinRaw    (extIrqPin[p]),
                .sampleEn  (ioClkRunning),
                .senseMode (senseMode[p]),
                .pinLevel  (pinLevel[p]),
                .trigger   (pinTrigger[p])
            );
            assign levelMode[p] = (senseMode[p] == SENSE_LOW_LEVEL);
        end
    endgenerate

    // Pin-change inputs: any change, needs no I/O clock enable
    genvar c;
    generate
        for (c = 0; c < PC_COUNT; c++) begin : g_pc
            pin_sense_stage u_sense (
                .core_clk  (core_clk),
                .rstn      (rstn),
                .pinRaw    (pinChangeInput[c]),
                .sampleEn  (1'b1),
                .senseMode (SENSE_ANY_CHANGE),
                .pinLevel  (pcLevel[c]),
                .trigger   (pcToggle[c])
            );
        end
    endgenerate

    assign pcHit = pcToggle & pinChangeMask;

    // Group bounds: top group is short, holding inputs 38..32
    genvar g;
    generate
        for (g = 0; g < PC_GROUPS; g++) begin : g_group
            localparam int LO = g * `PIN_CHANGE_GROUP_SIZE;
            localparam int HI = (LO + `PIN_CHANGE_GROUP_SIZE - 1 < PC_COUNT) ?
                                LO + `PIN_CHANGE_GROUP_SIZE - 1 : PC_COUNT - 1;
            assign pcGroupHit[g] = |pcHit[HI:LO];
            // Raw pad against last synchronised value, no clock needed
            assign pcGroupAsync[g] = pinChangeGroupEnable[g] &
                |((pinChangeInput[HI:LO] ^ pcLevel[HI:LO]) & pinChangeMask[HI:LO]);
        end
    endgenerate

    // Sense control register
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            sense_q <= `EXT_IRQ_SENSE_CONTROL_RESET;
        end else if (ioWrEn && selSense) begin
            sense_q <= ioWrData[5:0];
        end
    end

    // Enable register
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            enables_q <= `EXT_IRQ_ENABLES_RESET;
        end else if (ioWrEn && selEnables) begin
            enables_q <= ioWrData[PIN_COUNT-1:0];
        end
    end

    // Flags: a new trigger wins over a clear in the same cycle
    assign flagClear = (ioWrEn && selFlags) ? ioWrData[PIN_COUNT-1:0] : '0;
    always_comb begin
        flags_d = (flags_q & ~flagClear & ~extIrqAck) | pinTrigger;
        flags_d = flags_d & ~levelMode;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            flags_q <= `EXT_IRQ_FLAGS_RESET;
        end else begin
            flags_q <= flags_d;
        end
    end

    // Pin-change flags, cleared by vector entry only here
    always_comb begin
        pcFlags_d = (pcFlags_q & ~pinChangeAck) | pcGroupHit;
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            pcFlags_q <= '0;
        end else begin
            pcFlags_q <= pcFlags_d;
        end
    end

    assign pinChangeFlags = pcFlags_q;

    // Level mode follows the synchronised pin; a level gone by start-up end asks nothing
    always_comb begin
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (levelMode[i]) begin
                extIrqRequest[i] = ~pinLevel[i];
            end else begin
                extIrqRequest[i] = flags_q[i];
            end
        end
        extIrqRequest = extIrqRequest & enables_q & {PIN_COUNT{globalIrqEnable}};
    end

    assign pinChangeRequest = pcFlags_q & pinChangeGroupEnable & {PC_GROUPS{globalIrqEnable}};

    // Wake path is purely combinational so it works with every clock stopped
    always_comb begin
        wakeRequest = |pcGroupAsync;
        for (int i = 0; i < PIN_COUNT; i++) begin
            if (levelMode[i] && enables_q[i] && !extIrqPin[i]) begin
                wakeRequest = 1'b1;
            end
        end
    end

    // Read data registered one cycle after the strobe; unmapped reads zero
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            rdData_q <= 8'h00;
        end else if (ioRdEn) begin
            if (selFlags) begin
                // Mask again: a read just after a sense write would see the old flag
                rdData_q <= {5'h00, flags_q & ~levelMode};
            end else if (selEnables) begin
                rdData_q <= {5'h00, enables_q};
            end else if (selSense) begin
                rdData_q <= {2'h0, sense_q};
            end else begin
                rdData_q <= 8'h00;
            end
        end
    end

    assign ioRdData = rdData_q;

endmodule : external_pin_interrupt_unit

`default_nettype wire

// file: testbench/ext_irq_chk.sv
// Port checker for the external pin interrupt unit.
// Assumes every port lives in the core_clk domain.
`timescale 1ns/1ns
`default_nettype none

module ext_irq_chk #(
    parameter int PIN_COUNT = 3,
    parameter int PC_COUNT  = 39,
    parameter int PC_GROUPS = 5
)(
    // Clock and reset
    input wire logic                 core_clk,
    input wire logic                 rstn,
    // Watched ports
    input wire logic [PC_COUNT-1:0]  pinChangeInput,
    input wire logic [7:0]           ioAddr,
    input wire logic                 ioShortSpace,
    input wire logic                 ioRdEn,
    input wire logic [7:0]           ioRdData,
    input wire logic                 globalIrqEnable,
    input wire logic [PC_GROUPS-1:0] pinChangeGroupEnable,
    input wire logic [PIN_COUNT-1:0] extIrqRequest,
    input wire logic [PC_GROUPS-1:0] pinChangeRequest,
    input wire logic [PC_GROUPS-1:0] pinChangeAck,
    input wire logic [PC_GROUPS-1:0] pinChangeFlags
);
    logic [2:0]          quiet_q;
    logic [PC_COUNT-1:0] pcPrev_q;

    // Previous pad values kept in a register, pads idle high
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) pcPrev_q <= '1;
        else pcPrev_q <= pinChangeInput;
    end

    // Cycles since any pin-change input moved; saturates so triggers in flight are seen
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) quiet_q <= 3'h0;
        else if (pinChangeInput != pcPrev_q) quiet_q <= 3'h0;
        else if (quiet_q != 3'h7) quiet_q <= quiet_q + 3'h1;
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);

    chk_req_needs_gie: assert property (extIrqRequest != '0 |-> globalIrqEnable)
        else $error("Dedicated request without global enable");
    chk_pc_req_gate: assert property (
        pinChangeRequest == (pinChangeFlags & pinChangeGroupEnable & {PC_GROUPS{globalIrqEnable}}))
        else $error("Group request does not follow flag and enables");
    chk_pc_flag_cause: assert property (
        (pinChangeFlags & ~$past(pinChangeFlags)) != '0 |-> quiet_q < 3'h6)
        else $error("Group flag rose without a recent input change");
    chk_pc_ack_clear: assert property (
        pinChangeAck != '0 && quiet_q == 3'h7 |=> (pinChangeFlags & $past(pinChangeAck)) == '0)
        else $error("Acknowledged group flag stayed set");
    chk_pc_flag_hold: assert property (
        ($past(pinChangeFlags) & ~pinChangeFlags & ~$past(pinChangeAck)) == '0)
        else $error("Group flag dropped without acknowledge");
    chk_rd_unmapped: assert property (
        ioRdEn && ioShortSpace && ioAddr > 8'h3F |=> ioRdData == 8'h00)
        else $error("Unmapped short read not zero");
    chk_rd_hold: assert property (!ioRdEn |=> $stable(ioRdData))
        else $error("Read data moved without a read");
    chk_rd_upper: assert property (
        ioRdEn && !ioShortSpace && (ioAddr == 8'h3C || ioAddr == 8'h3D) |=> ioRdData[7:3] == 5'h00)
        else $error("Upper bits of flags or enables not zero");
endmodule : ext_irq_chk

bind external_pin_interrupt_unit ext_irq_chk #(
    .PIN_COUNT(PIN_COUNT), .PC_COUNT(PC_COUNT), .PC_GROUPS(PC_GROUPS)
) i_chk (
    .core_clk(core_clk), .rstn(rstn), .pinChangeInput(pinChangeInput), .ioAddr(ioAddr),
    .ioShortSpace(ioShortSpace), .ioRdEn(ioRdEn), .ioRdData(ioRdData),
    .globalIrqEnable(globalIrqEnable), .pinChangeGroupEnable(pinChangeGroupEnable),
    .extIrqRequest(extIrqRequest), .pinChangeRequest(pinChangeRequest),
    .pinChangeAck(pinChangeAck), .pinChangeFlags(pinChangeFlags)
);

`default_nettype wire

// file: testbench/ext_pin_source.sv
// Board-side source for the dedicated pins and the pin-change inputs.
// Assumes level commands from the bench; pads idle high.
`timescale 1ns/1ns
`default_nettype none

module ext_pin_source (
    // Clock
    input  wire logic        core_clk,
    // Requested levels
    input  wire logic [2:0]  pinCmd,
    input  wire logic [38:0] pcCmd,
    // Pads
    output logic      [2:0]  extIrqPin = 3'h7,
    output logic      [38:0] pinChangeInput = '1
);
    // Levels move only on an edge, so no pulse or low level is shorter than a period
    always @(posedge core_clk) begin
        extIrqPin      <= pinCmd;
        pinChangeInput <= pcCmd;
    end
endmodule : ext_pin_source

`default_nettype wire

// file: testbench/external_pin_interrupt_unit_tb.sv
// Bench for the external pin interrupt unit with a register-level model.
// Assumes the pin source model and the bound checker are compiled alongside.
`timescale 1ns/1ns
`default_nettype none

module external_pin_interrupt_unit_tb;
    logic core_clk = 0, rstn = 0, ioShortSpace = 0, ioWrEn = 0, ioRdEn = 0, wakeRequest;
    logic globalIrqEnable = 0, ioClkRunning = 1;
    logic [7:0] ioAddr = '0, ioWrData = '0, ioRdData;
    logic [2:0] pinCmd = 3'h7, extIrqPin, extIrqRequest, extIrqAck = '0;
    logic [38:0] pcCmd = '1, pinChangeInput, pinChangeMask = '0;
    logic [4:0] pinChangeGroupEnable = '0, pinChangeRequest, pinChangeAck = '0, pinChangeFlags;
    int n_mismatch = 0, n_tests = 0, mFlags = 0, mEn = 0, mSense = 0, lfsr = 46587, idx;

    ext_pin_source i_src (.core_clk(core_clk), .pinCmd(pinCmd), .pcCmd(pcCmd),
        .extIrqPin(extIrqPin), .pinChangeInput(pinChangeInput));
    external_pin_interrupt_unit i_dut (.core_clk(core_clk), .rstn(rstn), .extIrqPin(extIrqPin),
        .pinChangeInput(pinChangeInput), .ioAddr(ioAddr), .ioShortSpace(ioShortSpace),
        .ioWrEn(ioWrEn), .ioWrData(ioWrData), .ioRdEn(ioRdEn), .ioRdData(ioRdData),
        .globalIrqEnable(globalIrqEnable), .ioClkRunning(ioClkRunning),
        .pinChangeGroupEnable(pinChangeGroupEnable), .pinChangeMask(pinChangeMask),
        .extIrqRequest(extIrqRequest), .extIrqAck(extIrqAck),
        .pinChangeRequest(pinChangeRequest), .pinChangeAck(pinChangeAck),
        .pinChangeFlags(pinChangeFlags), .wakeRequest(wakeRequest));

    initial begin
        forever #5 core_clk = ~core_clk;
    end

    function automatic int lfsrNext(int x);
        return ((x << 1) | (((x >> 15) ^ (x >> 13) ^ (x >> 12) ^ (x >> 10)) & 1)) & 16'hFFFF;
    endfunction : lfsrNext

    function automatic int mode(int i);
        return (mSense >> 2 * i) & 3;
    endfunction : mode

    // Level pins follow the pad; edge pins follow the modelled flag
    function automatic int expReq();
        int r = 0;
        for (int i = 0; i < 3; i++)
            if (mode(i) == 0 ? !pinCmd[i] : mFlags[i]) r |= 1 << i;
        return globalIrqEnable ? r & mEn : 0;
    endfunction : expReq

    task automatic tick(int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask : tick

    task automatic check(logic [7:0] got, int exp);
        n_tests++;
        if (got !== exp[7:0]) begin
            n_mismatch++;
            $display("BAD t=%0t got %h expected %h", $time, got, exp[7:0]);
        end
    endtask : check

    task automatic io(logic wr, logic shrt, logic [7:0] a, logic [7:0] d);
        int da;
        da = shrt ? (a > 8'h3F ? 0 : a + 8'h20) : a;
        {ioWrEn, ioRdEn, ioShortSpace, ioAddr, ioWrData} = {wr, !wr, shrt, a, d};
        tick(1);
        {ioWrEn, ioRdEn} = 2'h0;
        if (!wr) check(ioRdData, da == 8'h3C ? mFlags : da == 8'h3D ? mEn : da == 8'h69 ? mSense : 0);
        else if (da == 8'h3C) mFlags &= ~d;
        else if (da == 8'h3D) mEn = d & 7;
        else if (da == 8'h69) begin
            mSense = d & 8'h3F;
            for (int i = 0; i < 3; i++)
                if (mode(i) == 0) mFlags &= ~(1 << i);
        end
        tick(1);
    endtask : io

    task automatic pins(logic [2:0] v, int wake);
        logic [2:0] p;
        int old;
        p = pinCmd;
        old = expReq();
        pinCmd = v;
        tick(1);
        check(extIrqRequest, old);
        if (wake >= 0) check(wakeRequest, wake);
        for (int i = 0; i < 3; i++)
            if (p[i] != v[i] && ioClkRunning && (mode(i) == 1 || mode(i) == (v[i] ? 3 : 2)))
                mFlags |= 1 << i;
        tick(6);
        check(extIrqRequest, expReq());
        io(0, 1, 8'h1C, 8'h00);
    endtask : pins

    task automatic final_report();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : final_report

    initial begin
        tick(20);
        rstn = 1;
        io(0, 0, 8'h3C, 8'h00);
        io(0, 1, 8'h1D, 8'h00);
        lfsr = lfsrNext(lfsr);
        io(1, 0, 8'h69, lfsr[7:0]);
        io(0, 0, 8'h69, 8'h00);
        io(1, 1, 8'h49, 8'hFF);
        io(0, 1, 8'h49, 8'h00);
        io(0, 0, 8'h69, 8'h00);
        io(1, 1, 8'h1D, 8'hFF);
        io(0, 0, 8'h3D, 8'h00);
        io(0, 0, 8'h50, 8'h00);
        globalIrqEnable = 1;
        for (int m = 1; m < 4; m++) begin
            io(1, 0, 8'h69, 8'((m % 3 + 1) | ((m + 1) % 3 + 1) << 2 | ((m + 2) % 3 + 1) << 4));
            io(1, 0, 8'h3C, 8'h07);
            pins(3'h0, -1);
            extIrqAck = 3'h1;
            tick(1);
            extIrqAck = '0;
            mFlags &= ~1;
            tick(1);
            check(extIrqRequest, expReq());
            pins(3'h7, -1);
            globalIrqEnable = 0;
            tick(1);
            check(extIrqRequest, 0);
            globalIrqEnable = 1;
        end
        io(1, 0, 8'h69, 8'h00);
        pins(3'h0, 1);
        tick(10);
        check(extIrqRequest, 7);
        pins(3'h7, 0);
        io(1, 0, 8'h69, 8'h2A);
        io(1, 0, 8'h3C, 8'h07);
        ioClkRunning = 0;
        pins(3'h0, -1);
        ioClkRunning = 1;
        pins(3'h7, -1);
        pinChangeMask = '1;
        pinChangeGroupEnable = 5'h1F;
        for (int g = 0; g < 5; g++) begin
            lfsr = lfsrNext(lfsr);
            idx = g * 8 + lfsr % (g == 4 ? 7 : 8);
            pcCmd[idx] = ~pcCmd[idx];
            tick(1);
            check(wakeRequest, 1);
            tick(6);
            check(pinChangeFlags, 1 << g);
            check(pinChangeRequest, 1 << g);
            pinChangeGroupEnable[g] = 0;
            tick(2);
            check(pinChangeRequest, 0);
            pinChangeGroupEnable[g] = 1;
            pinChangeAck[g] = 1;
            tick(1);
            pinChangeAck[g] = 0;
            tick(1);
            check(pinChangeFlags, 0);
            pinChangeMask[idx] = 0;
            pcCmd[idx] = ~pcCmd[idx];
            tick(8);
            check(pinChangeFlags, 0);
            pinChangeMask[idx] = 1;
        end
        final_report();
    end
endmodule : external_pin_interrupt_unit_tb

`default_nettype wire
